// ### alarm_status_pkg.sv
// register map, field positions and carrier types of the clock alarm status block
// assumes a serial-port front end that turns bus frames into byte read and write strobes
package alarm_status_pkg;

  // register offsets on the serial configuration port
  localparam logic [7:0] ADDR_LIVE_SIGNAL_LOSS   = 8'h81;
  localparam logic [7:0] ADDR_LIVE_ALARM_STATUS  = 8'h82;
  localparam logic [7:0] ADDR_SIGNAL_LOSS_STICKY = 8'h83;
  localparam logic [7:0] ADDR_OFFSET_LOCK_STICKY = 8'h84;
  localparam logic [7:0] ADDR_PART_NUMBER_HIGH   = 8'h86;
  localparam logic [7:0] ADDR_PART_NUMBER_LOW    = 8'h87;

  // live alarm status field positions
  localparam int BIT_HOLDOVER_VALID = 6;
  localparam int BIT_TWO_OFFSET     = 2;
  localparam int BIT_ONE_OFFSET     = 1;
  localparam int BIT_PLL_UNLOCK     = 0;

  // live signal loss and signal loss sticky field positions
  localparam int BIT_TWO_LOSS = 2;
  localparam int BIT_ONE_LOSS = 1;
  localparam int BIT_REF_LOSS = 0;

  // offset and lock sticky field positions
  localparam int BIT_TWO_OFFSET_STICKY = 3;
  localparam int BIT_ONE_OFFSET_STICKY = 2;
  localparam int BIT_UNLOCK_STICKY     = 1;

  // index of each flag inside the sticky flag vector
  localparam int NUM_FLAGS      = 6;
  localparam int FLAG_REF_LOSS  = 0;
  localparam int FLAG_ONE_LOSS  = 1;
  localparam int FLAG_TWO_LOSS  = 2;
  localparam int FLAG_UNLOCK    = 3;
  localparam int FLAG_ONE_OFF   = 4;
  localparam int FLAG_TWO_OFF   = 5;

  // reset values
  localparam logic [NUM_FLAGS-1:0] FLAGS_RESET = 6'h00;
  localparam logic [7:0]           RDATA_RESET = 8'h00;

  // identification codes, values arbitrary
  localparam logic [11:0] PART_NUMBER_CODE = 12'h5a3;
  localparam logic [3:0]  REVISION_CODE    = 4'h7;

  typedef struct packed {
    logic holdover_history_valid;
    logic input_two_offset_live;
    logic input_one_offset_live;
    logic pll_unlock_live;
    logic input_two_signal_loss_live;
    logic input_one_signal_loss_live;
    logic reference_signal_loss_live;
  } live_alarm_t;

  typedef struct packed {
    logic input_two_offset_mask;
    logic input_one_offset_mask;
    logic pll_unlock_mask;
    logic input_two_signal_loss_mask;
    logic input_one_signal_loss_mask;
    logic reference_signal_loss_mask;
  } alarm_mask_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       write;
    logic       read;
    logic [7:0] wdata;
  } reg_req_t;

endpackage

// ### sticky_flags.sv
// bank of sticky alarm flags, one per live alarm
// assumes live alarms and clear strobes are synchronous to mclk
`timescale 1ns/1ps

module sticky_flags
(
  // clock and reset
  input  wire logic                                mclk,
  input  wire logic                                reset,
  // live alarms and clear requests
  input  wire logic [alarm_status_pkg::NUM_FLAGS-1:0] live,
  input  wire logic [alarm_status_pkg::NUM_FLAGS-1:0] clear,
  // held flags
  output logic      [alarm_status_pkg::NUM_FLAGS-1:0] flags
);
  import alarm_status_pkg::*;

  typedef struct packed {
    logic [NUM_FLAGS-1:0] flags;
  } flag_state_t;

  flag_state_t          state;
  flag_state_t          next_state;
  logic [NUM_FLAGS-1:0] next_bits;

  ////////////////////////////////////////////////////////////////////////////////
  genvar i;
  generate
    for (i = 0; i < NUM_FLAGS; i++)
    begin : g_flag
      // set wins over clear so an alarm in the clearing cycle is kept
      assign next_bits[i] = live[i] | (state.flags[i] & ~clear[i]);
    end
  endgenerate

  always_comb
  begin
    next_state       = state;
    next_state.flags = next_bits;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      state.flags <= FLAGS_RESET;
    else
      state <= next_state;
  end

  assign flags = state.flags;

endmodule

// ### clock_alarm_status_flags.sv
// alarm status, sticky flags, interrupt pin and identification registers
// assumes the serial port front end issues one-cycle byte read and write strobes
// Operation
// - status bit 6 reads 1 once the holdover history is filled.
// - status bit 2 shows the live offset alarm of input two.
// - status bit 1 shows the live offset alarm of input one.
// - status bit 0 reads 1 while the pll is unlocked.
// - signal loss flag register bits 2,1,0 latch input two, one, reference loss.
// - a flag stays set until software writes 0 to that bit only.
// - flags reach the interrupt pin only while the pin enable is 1.
// - each flag has a mask bit; a masked flag never raises the interrupt.
// - offset flag register bit 3 latches input two, bit 2 input one offset.
// - offset flag register bit 1 latches pll unlock and can interrupt.
// - twelve-bit part number split over two read-only identification registers.
// - four-bit revision code sits in the low nibble of the second id register.
// - live loss bits 2,1,0 show input two, input one, reference loss.
`timescale 1ns/1ps

module clock_alarm_status_flags
(
  // clock and reset
  input  wire logic                          mclk,
  input  wire logic                          reset,
  // register port from the serial front end
  input  wire alarm_status_pkg::reg_req_t    reg_req,
  output logic [7:0]                         reg_rdata,
  output logic                               reg_rvalid,
  // live alarms from the detectors
  input  wire alarm_status_pkg::live_alarm_t live_alarm,
  // interrupt settings
  input  wire alarm_status_pkg::alarm_mask_t alarm_mask,
  input  wire logic                          int_pin_enable,
  // interrupt pin
  output logic                               irq
);
  import alarm_status_pkg::*;

  typedef struct packed {
    logic [7:0] rdata;
    logic       rvalid;
    logic       irq;
  } port_state_t;

  port_state_t          state;
  port_state_t          next_state;
  logic [NUM_FLAGS-1:0] live_vec;
  logic [NUM_FLAGS-1:0] mask_vec;
  logic [NUM_FLAGS-1:0] clear_vec;
  logic [NUM_FLAGS-1:0] flags;
  logic [7:0]           live_status_byte;
  logic [7:0]           live_loss_byte;
  logic [7:0]           loss_flag_byte;
  logic [7:0]           offset_flag_byte;
  logic                 pending;

  ////////////////////////////////////////////////////////////////////////////////
  // flag vector ordering

  always_comb
  begin
    live_vec                = '0;
    live_vec[FLAG_REF_LOSS] = live_alarm.reference_signal_loss_live;
    live_vec[FLAG_ONE_LOSS] = live_alarm.input_one_signal_loss_live;
    live_vec[FLAG_TWO_LOSS] = live_alarm.input_two_signal_loss_live;
    live_vec[FLAG_UNLOCK]   = live_alarm.pll_unlock_live;
    live_vec[FLAG_ONE_OFF]  = live_alarm.input_one_offset_live;
    live_vec[FLAG_TWO_OFF]  = live_alarm.input_two_offset_live;
    mask_vec                = '0;
    mask_vec[FLAG_REF_LOSS] = alarm_mask.reference_signal_loss_mask;
    mask_vec[FLAG_ONE_LOSS] = alarm_mask.input_one_signal_loss_mask;
    mask_vec[FLAG_TWO_LOSS] = alarm_mask.input_two_signal_loss_mask;
    mask_vec[FLAG_UNLOCK]   = alarm_mask.pll_unlock_mask;
    mask_vec[FLAG_ONE_OFF]  = alarm_mask.input_one_offset_mask;
    mask_vec[FLAG_TWO_OFF]  = alarm_mask.input_two_offset_mask;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // clear decode: only bits written as zero are cleared

  always_comb
  begin
    clear_vec = '0;
    if (reg_req.write && reg_req.addr == ADDR_SIGNAL_LOSS_STICKY)
    begin
      clear_vec[FLAG_REF_LOSS] = ~reg_req.wdata[BIT_REF_LOSS];
      clear_vec[FLAG_ONE_LOSS] = ~reg_req.wdata[BIT_ONE_LOSS];
      clear_vec[FLAG_TWO_LOSS] = ~reg_req.wdata[BIT_TWO_LOSS];
    end
    if (reg_req.write && reg_req.addr == ADDR_OFFSET_LOCK_STICKY)
    begin
      clear_vec[FLAG_UNLOCK]  = ~reg_req.wdata[BIT_UNLOCK_STICKY];
      clear_vec[FLAG_ONE_OFF] = ~reg_req.wdata[BIT_ONE_OFFSET_STICKY];
      clear_vec[FLAG_TWO_OFF] = ~reg_req.wdata[BIT_TWO_OFFSET_STICKY];
    end
  end

  sticky_flags u_flags
  (
    .mclk  (mclk),
    .reset (reset),
    .live  (live_vec),
    .clear (clear_vec),
    .flags (flags)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // read byte assembly, reserved bits read zero

  always_comb
  begin
    live_status_byte                     = '0;
    live_status_byte[BIT_HOLDOVER_VALID] = live_alarm.holdover_history_valid;
    live_status_byte[BIT_TWO_OFFSET]     = live_alarm.input_two_offset_live;
    live_status_byte[BIT_ONE_OFFSET]     = live_alarm.input_one_offset_live;
    live_status_byte[BIT_PLL_UNLOCK]     = live_alarm.pll_unlock_live;
    live_loss_byte                       = '0;
    live_loss_byte[BIT_TWO_LOSS]         = live_alarm.input_two_signal_loss_live;
    live_loss_byte[BIT_ONE_LOSS]         = live_alarm.input_one_signal_loss_live;
    live_loss_byte[BIT_REF_LOSS]         = live_alarm.reference_signal_loss_live;
    loss_flag_byte                       = '0;
    loss_flag_byte[BIT_TWO_LOSS]         = flags[FLAG_TWO_LOSS];
    loss_flag_byte[BIT_ONE_LOSS]         = flags[FLAG_ONE_LOSS];
    loss_flag_byte[BIT_REF_LOSS]         = flags[FLAG_REF_LOSS];
    offset_flag_byte                     = '0;
    offset_flag_byte[BIT_TWO_OFFSET_STICKY] = flags[FLAG_TWO_OFF];
    offset_flag_byte[BIT_ONE_OFFSET_STICKY] = flags[FLAG_ONE_OFF];
    offset_flag_byte[BIT_UNLOCK_STICKY]     = flags[FLAG_UNLOCK];
  end

  // masked-off flags still read back set, they only stay off the pin
  assign pending = |(flags & ~mask_vec);

  ////////////////////////////////////////////////////////////////////////////////
  // registered read port and interrupt pin

  always_comb
  begin
    next_state        = state;
    next_state.rvalid = reg_req.read;
    next_state.irq    = pending & int_pin_enable;
    if (reg_req.read)
    begin
      unique case (reg_req.addr)
        ADDR_LIVE_SIGNAL_LOSS:   next_state.rdata = live_loss_byte;
        ADDR_LIVE_ALARM_STATUS:  next_state.rdata = live_status_byte;
        ADDR_SIGNAL_LOSS_STICKY: next_state.rdata = loss_flag_byte;
        ADDR_OFFSET_LOCK_STICKY: next_state.rdata = offset_flag_byte;
        ADDR_PART_NUMBER_HIGH:   next_state.rdata = PART_NUMBER_CODE[11:4];
        ADDR_PART_NUMBER_LOW:    next_state.rdata = {PART_NUMBER_CODE[3:0], REVISION_CODE};
        default:                 next_state.rdata = RDATA_RESET;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      state.rdata  <= RDATA_RESET;
      state.rvalid <= 1'h0;
      state.irq    <= 1'h0;
    end
    else
      state <= next_state;
  end

  assign reg_rdata  = state.rdata;
  assign reg_rvalid = state.rvalid;
  assign irq        = state.irq;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  logic [NUM_FLAGS-1:0] clear_no_live;
  assign clear_no_live = clear_vec & ~live_vec;

  a_flag_sets: assert property (@(posedge mclk) disable iff (reset)
    (live_vec != '0) |=> ((flags & $past(live_vec)) == $past(live_vec)))
    else $error("live alarm did not set its flag");

  a_flag_holds: assert property (@(posedge mclk) disable iff (reset)
    ((($past(flags) & ~$past(clear_vec)) & ~flags) == '0))
    else $error("flag dropped without a zero write");

  a_flag_clears: assert property (@(posedge mclk) disable iff (reset)
    (clear_no_live != '0) |=> ((flags & $past(clear_no_live)) == '0))
    else $error("zero write did not clear flag");

  a_pin_disabled: assert property (@(posedge mclk) disable iff (reset)
    !int_pin_enable |=> !irq)
    else $error("interrupt active with pin disabled");

  a_mask_gates: assert property (@(posedge mclk) disable iff (reset)
    irq |-> $past(pending) && $past(int_pin_enable))
    else $error("interrupt without unmasked flag");

  a_irq_raises: assert property (@(posedge mclk) disable iff (reset)
    (pending && int_pin_enable) |=> irq)
    else $error("unmasked flag did not raise interrupt");

  a_read_timing: assert property (@(posedge mclk) disable iff (reset)
    reg_rvalid == $past(reg_req.read))
    else $error("read answer not one cycle after request");

  // expected bytes rebuilt from the live inputs, not from the read mux
  a_status_read: assert property (@(posedge mclk) disable iff (reset)
    (reg_req.read && reg_req.addr == ADDR_LIVE_ALARM_STATUS) |=>
      reg_rdata == {1'h0, $past(live_alarm.holdover_history_valid), 3'h0,
                    $past(live_alarm.input_two_offset_live),
                    $past(live_alarm.input_one_offset_live),
                    $past(live_alarm.pll_unlock_live)})
    else $error("live status read wrong");

  a_loss_read: assert property (@(posedge mclk) disable iff (reset)
    (reg_req.read && reg_req.addr == ADDR_LIVE_SIGNAL_LOSS) |=>
      reg_rdata == {5'h00, $past(live_alarm.input_two_signal_loss_live),
                    $past(live_alarm.input_one_signal_loss_live),
                    $past(live_alarm.reference_signal_loss_live)})
    else $error("live loss read wrong");

  a_loss_flags: assert property (@(posedge mclk) disable iff (reset)
    (reg_req.read && reg_req.addr == ADDR_SIGNAL_LOSS_STICKY) |=>
      reg_rdata == {5'h00, $past(flags[FLAG_TWO_LOSS]), $past(flags[FLAG_ONE_LOSS]),
                    $past(flags[FLAG_REF_LOSS])})
    else $error("loss flag read wrong");

  a_id_read: assert property (@(posedge mclk) disable iff (reset)
    (reg_req.read && reg_req.addr == ADDR_PART_NUMBER_HIGH) |=> reg_rdata == PART_NUMBER_CODE[11:4])
    else $error("part number high read wrong");

  a_rev_read: assert property (@(posedge mclk) disable iff (reset)
    (reg_req.read && reg_req.addr == ADDR_PART_NUMBER_LOW) |=> reg_rdata[3:0] == REVISION_CODE)
    else $error("revision read wrong");

  a_reserved_zero: assert property (@(posedge mclk) disable iff (reset)
    (reg_req.read && reg_req.addr == ADDR_OFFSET_LOCK_STICKY) |=> reg_rdata[7:4] == 4'h0 && !reg_rdata[0])
    else $error("reserved flag bits not zero");

endmodule

// ### alarm_host_model.sv
// host side of the register port: byte reads and writes as the serial front end delivers them
// assumes one-cycle strobes taken on rising mclk and read data valid the cycle after the read edge
`timescale 1ns/1ps

module alarm_host_model
(
  // clock
  input  wire logic                   mclk,
  // register port
  output alarm_status_pkg::reg_req_t  reg_req,
  input  wire logic [7:0]             reg_rdata,
  input  wire logic                   reg_rvalid
);
  import alarm_status_pkg::*;

  initial reg_req = '0;

  ////////////////////////////////////////////////////////////////////////////////
  // a released address byte shows its inverse; a write releases its data byte inverted, a read restores the data byte held before it
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_req <= '{addr: a, write: 1'h1, read: 1'h0, wdata: d};
    @(posedge mclk);
    reg_req <= '{addr: ~a, write: 1'h0, read: 1'h0, wdata: ~d};
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge mclk);
    reg_req <= '{addr: a, write: 1'h0, read: 1'h1, wdata: ~reg_req.wdata};
    @(posedge mclk);
    reg_req <= '{addr: ~a, write: 1'h0, read: 1'h0, wdata: ~reg_req.wdata};
    #1;
    v = reg_rvalid;
    d = reg_rdata;
  endtask
endmodule

// ### tb_clock_alarm_status_flags.sv
// testbench of the alarm status block: live bits, sticky flags, interrupt pin, id registers
// assumes the host model drives the register port; live alarms and masks come from here
`timescale 1ns/1ps

module tb_clock_alarm_status_flags;
  import alarm_status_pkg::*;

  logic        mclk           = 1'h0;
  logic        reset          = 1'h1;
  reg_req_t    reg_req;
  logic [7:0]  reg_rdata;
  logic        reg_rvalid;
  live_alarm_t live_alarm     = '0;
  alarm_mask_t alarm_mask     = '0;
  logic        int_pin_enable = 1'h0;
  logic        irq;
  int          err_total      = 0;
  int          tests_run      = 0;
  live_alarm_t lv;
  logic [7:0]  e_loss;
  logic [7:0]  e_st;
  logic [7:0]  e_ol;
  logic        e_irq;

  always #10 mclk = ~mclk;

  clock_alarm_status_flags i_clock_alarm_status_flags
  (
    .mclk           (mclk),
    .reset          (reset),
    .reg_req        (reg_req),
    .reg_rdata      (reg_rdata),
    .reg_rvalid     (reg_rvalid),
    .live_alarm     (live_alarm),
    .alarm_mask     (alarm_mask),
    .int_pin_enable (int_pin_enable),
    .irq            (irq)
  );

  alarm_host_model i_alarm_host_model
  (
    .mclk       (mclk),
    .reg_req    (reg_req),
    .reg_rdata  (reg_rdata),
    .reg_rvalid (reg_rvalid)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("tests_run=%0d err_total=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] expd);
    tests_run++;
    if (seen !== expd)
    begin
      err_total++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, expd);
    end
  endtask

  task automatic expect_reg(input logic [7:0] a, input logic [7:0] expd);
    logic [7:0] d;
    logic       v;
    i_alarm_host_model.reg_read(a, d, v);
    check({7'h00, v}, 8'h01);
    check(d, expd);
  endtask

  task automatic drive_live(input logic [6:0] v, input int hold);
    @(posedge mclk);
    live_alarm <= live_alarm_t'(v);
    repeat (hold) @(posedge mclk);
  endtask

  // irq is registered behind the flags, so two edges cover any change
  task automatic expect_irq(input logic e);
    repeat (2) @(posedge mclk);
    #1;
    check({7'h00, irq}, {7'h00, e});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge mclk);
    err_total++;
    end_of_test();
  end

  initial
  begin
    repeat (16) @(posedge mclk);
    reset <= 1'h0;
    expect_reg(ADDR_PART_NUMBER_HIGH, PART_NUMBER_CODE[11:4]);
    expect_reg(ADDR_PART_NUMBER_LOW, {PART_NUMBER_CODE[3:0], REVISION_CODE});
    i_alarm_host_model.reg_write(ADDR_PART_NUMBER_LOW, 8'h00);
    expect_reg(ADDR_PART_NUMBER_LOW, {PART_NUMBER_CODE[3:0], REVISION_CODE});
    expect_reg(8'h85, 8'h00);
    @(posedge mclk);
    int_pin_enable <= 1'h1;
    // one live alarm at a time, through live bits, flag, mask and enable
    for (int i = 0; i < 7; i++)
    begin
      lv = live_alarm_t'(7'h01 << i);
      e_loss = {5'h00, lv.input_two_signal_loss_live, lv.input_one_signal_loss_live, lv.reference_signal_loss_live};
      e_st = {1'h0, lv.holdover_history_valid, 3'h0, lv.input_two_offset_live, lv.input_one_offset_live,
              lv.pll_unlock_live};
      e_ol = {4'h0, lv.input_two_offset_live, lv.input_one_offset_live, lv.pll_unlock_live, 1'h0};
      e_irq = (i < 6);
      drive_live(lv, 1);
      expect_reg(ADDR_LIVE_SIGNAL_LOSS, e_loss);
      expect_reg(ADDR_LIVE_ALARM_STATUS, e_st);
      drive_live(7'h00, 1);
      expect_reg(ADDR_SIGNAL_LOSS_STICKY, e_loss);
      expect_reg(ADDR_OFFSET_LOCK_STICKY, e_ol);
      expect_irq(e_irq);
      @(posedge mclk);
      alarm_mask <= alarm_mask_t'(6'h01 << i);
      expect_irq(1'h0);
      @(posedge mclk);
      alarm_mask <= '0;
      int_pin_enable <= 1'h0;
      expect_irq(1'h0);
      @(posedge mclk);
      int_pin_enable <= 1'h1;
      expect_irq(e_irq);
      i_alarm_host_model.reg_write(ADDR_SIGNAL_LOSS_STICKY, 8'h00);
      i_alarm_host_model.reg_write(ADDR_OFFSET_LOCK_STICKY, 8'h00);
      expect_irq(1'h0);
    end
    // zeros clear only their own bit
    drive_live(7'h3f, 1);
    drive_live(7'h00, 1);
    i_alarm_host_model.reg_write(ADDR_SIGNAL_LOSS_STICKY, 8'h06);
    expect_reg(ADDR_SIGNAL_LOSS_STICKY, 8'h06);
    i_alarm_host_model.reg_write(ADDR_OFFSET_LOCK_STICKY, 8'hfb);
    expect_reg(ADDR_OFFSET_LOCK_STICKY, 8'h0a);
    // a live alarm still high outlasts a clear
    drive_live(7'h04, 0);
    i_alarm_host_model.reg_write(ADDR_SIGNAL_LOSS_STICKY, 8'h00);
    expect_reg(ADDR_SIGNAL_LOSS_STICKY, 8'h04);
    drive_live(7'h00, 1);
    // reset in mid-run drops held flags and the pin
    @(posedge mclk);
    reset <= 1'h1;
    repeat (2) @(posedge mclk);
    reset <= 1'h0;
    expect_reg(ADDR_SIGNAL_LOSS_STICKY, 8'h00);
    expect_reg(ADDR_OFFSET_LOCK_STICKY, 8'h00);
    check({7'h00, irq}, 8'h00);
    end_of_test();
  end
endmodule
